// ### include/swg_params.svh
// Offsets, field positions, reset values and timing counts of the global id/start/flush bank.
`ifndef SWG_PARAMS_SVH
`define SWG_PARAMS_SVH

// Register addresses in the 8-bit management address space.
`define SWG_ADDR_FAMILY   8'h00
`define SWG_ADDR_ID_START 8'h01
`define SWG_ADDR_GCTRL0   8'h02

// Field positions.
`define SWG_START_BIT     0
`define SWG_BACKOFF_BIT   7
`define SWG_FLUSH_DYN_BIT 5
`define SWG_FLUSH_STA_BIT 4

// Reset values.
`define SWG_REVISION_RST  3'h0
`define SWG_START_RST     1'b0
`define SWG_BACKOFF_RST   1'b0

// Management frame layout.
`define SWG_PREAMBLE_ONES 6'h20
`define SWG_HDR_LAST      4'hB
`define SWG_DATA_LAST     4'hF
`define SWG_OP_READ       2'h2
`define SWG_OP_WRITE      2'h1

// Configuration memory layout and strap settle count.
`define SWG_EE_LAST_ADDR  8'h02
`define SWG_STRAP_SETTLE  2'h3

`endif

// ### include/swg_pkg.sv
// Types shared by the global id/start/flush bank.
package swg_pkg;

  // Management frame receiver states.
  typedef enum logic [2:0] {
    SM_PRE = 3'b000,
    SM_ST  = 3'b001,
    SM_HDR = 3'b010,
    SM_TA  = 3'b011,
    SM_RD  = 3'b100,
    SM_WR  = 3'b101
  } swg_smi_state_t;

  // Configuration memory loader states.
  typedef enum logic [1:0] {
    EE_WAIT = 2'b00,
    EE_REQ  = 2'b01,
    EE_DATA = 2'b10,
    EE_DONE = 2'b11
  } swg_ee_state_t;

  // Decoded frame header: opcode, device address and register address.
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy_addr_field;
    logic [4:0] reg_addr_field;
  } swg_hdr_t;

  // Request handed to the address table for a flush.
  typedef struct packed {
    logic       active;
    logic [4:0] port_mask;
  } swg_flush_t;

endpackage

// ### src/swg_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module swg_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;  // First stage, read only by the second stage.

  // One pair of flops per bit; the first flop feeds nothing but the second.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule

// ### src/swg_regs.sv
// Global id, start-switch and table-flush registers behind the serial management port.
//
// Summary of operation
// R1: Revision field bits 3:1 read zero.
// R2: Writing start bit starts switch in host mode.
// R3: Start bit zero keeps switch idle.
// R4: Strap (0,0) auto-starts after memory read attempt.
// R5: No memory found keeps all defaults.
// R6: Load memory only if id bytes check.
// R7: Board never straps (1,1) in use.
// R8: Control bit 7 selects alternative back-off.
// R9: Control bit 5 triggers self-clearing dynamic flush.
// R10: Dynamic flush only learning-disabled ports.
// R11: Control bit 4 triggers self-clearing static flush.
// R12: Static flush single-port unicast, learning-disabled entries.
// R13: Address is phy bits 4,3,0 plus register.
// R14: Upper data byte reads zero, writes ignored.
// R15: Flush bits read one until done.
`timescale 1ns/1ps
`include "swg_params.svh"
module swg_regs
  import swg_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'hA5,  // Arbitrary value.
  parameter logic [3:0] CHIP_CODE   = 4'h3    // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Management pins.
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  // Mode straps.
  input  wire logic       mode_strap_high,
  input  wire logic       mode_strap_low,
  // Configuration memory byte port.
  input  wire logic       ee_present,
  output logic            ee_req,
  output logic [7:0]      ee_addr,
  input  wire logic       ee_rvalid,
  input  wire logic [7:0] ee_rdata,
  // Switch core controls.
  output logic            switch_start,
  output logic            backoff_alt,
  input  wire logic [4:0] learn_dis,
  output swg_flush_t      flush_dyn,
  input  wire logic       flush_dyn_done,
  output swg_flush_t      flush_sta,
  input  wire logic       flush_sta_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and strap capture.

  logic [3:0]     pins_s;       // Synchronised mdc, mdio, straps.
  logic           mdc_prev_q;   // Previous synchronised clock level.
  logic           mdc_rise;     // One-cycle pulse on a management clock rise.
  logic [1:0]     settle_q;     // Wait for the synchroniser to fill.
  logic [1:0]     strap_q;      // Straps captured after reset release.
  logic           strap_ok_q;   // Straps have been captured.
  logic           host_mode;    // Straps select a host-started switch.

  swg_sync #(.W(4)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({mdc, mdio_i, mode_strap_high, mode_strap_low}),
    .sync_out (pins_s)
  );

  // Edges are ignored until the straps are caught. The synchroniser leaves reset low while the
  // management clock may idle high, and that would otherwise look like a false rise.
  assign mdc_rise  = pins_s[3] & ~mdc_prev_q & strap_ok_q;
  assign host_mode = strap_ok_q & (strap_q[1] ^ strap_q[0]);

  // The straps are caught a few cycles after release so the synchroniser holds real levels.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdc_prev_q <= 1'b0;
      settle_q   <= 2'h0;
      strap_q    <= 2'h0;
      strap_ok_q <= 1'b0;
    end else begin
      mdc_prev_q <= pins_s[3];
      if (!strap_ok_q) begin
        if (settle_q == `SWG_STRAP_SETTLE) begin
          strap_q    <= pins_s[1:0];
          strap_ok_q <= 1'b1;
        end else begin
          settle_q <= settle_q + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management frame receiver and transmitter.

  swg_smi_state_t smi_q;        // Frame state.
  logic [5:0]     ones_q;       // Preamble ones, saturating.
  logic [3:0]     cnt_q;        // Bit counter inside a field.
  logic [11:0]    hdr_q;        // Header shift register.
  swg_hdr_t       hdr_w;        // Header including the current bit.
  logic           is_read_q;    // Frame is a read.
  logic [7:0]     addr_q;       // Register address of the frame.
  logic [15:0]    sh_q;         // Data shift register, both directions.
  logic           wr_q;         // One-cycle register write strobe.
  logic [7:0]     wr_data_q;    // Low byte of the written data.
  logic [7:0]     rd_data;      // Register read mux.

  assign hdr_w = swg_hdr_t'({hdr_q[10:0], pins_s[2]});

  // Bits are sampled on clock rises; read data changes on the same rise so the host
  // sees it settled for a management period less three clocks before its next rise.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      smi_q     <= SM_PRE;
      ones_q    <= 6'h00;
      cnt_q     <= 4'h0;
      hdr_q     <= 12'h000;
      is_read_q <= 1'b0;
      addr_q    <= 8'h00;
      sh_q      <= 16'h0000;
      wr_q      <= 1'b0;
      wr_data_q <= 8'h00;
      mdio_o    <= 1'b0;
      mdio_oe   <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (mdc_rise) begin
        case (smi_q)
          SM_PRE: begin
            // Count ones; a zero after enough ones is the first start bit.
            if (pins_s[2]) begin
              if (ones_q != `SWG_PREAMBLE_ONES) begin
                ones_q <= ones_q + 6'h01;
              end
            end else if (ones_q == `SWG_PREAMBLE_ONES) begin
              smi_q <= SM_ST;
            end else begin
              ones_q <= 6'h00;
            end
          end
          SM_ST: begin
            ones_q <= 6'h00;
            cnt_q  <= 4'h0;
            smi_q  <= pins_s[2] ? SM_HDR : SM_PRE;
          end
          SM_HDR: begin
            hdr_q <= hdr_w;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `SWG_HDR_LAST) begin
              cnt_q  <= 4'h0;
              // Only frames whose device address has bits 2:1 set belong to this bank.
              addr_q <= {hdr_w.phy_addr_field[4:3], hdr_w.phy_addr_field[0],
                         hdr_w.reg_addr_field};  // R13
              if (hdr_w.phy_addr_field[2:1] == 2'h3 && hdr_w.op == `SWG_OP_READ) begin
                is_read_q <= 1'b1;
                smi_q     <= SM_TA;
              end else if (hdr_w.phy_addr_field[2:1] == 2'h3 &&
                           hdr_w.op == `SWG_OP_WRITE) begin
                is_read_q <= 1'b0;
                smi_q     <= SM_TA;
              end else begin
                smi_q <= SM_PRE;
              end
            end
          end
          SM_TA: begin
            // First turnaround bit leaves the line free; the second is driven low on reads.
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h0) begin
              mdio_oe <= is_read_q;
              mdio_o  <= 1'b0;
            end else begin
              cnt_q <= 4'h0;
              if (is_read_q) begin
                mdio_o <= 1'b0;                    // R14
                sh_q   <= {7'h00, rd_data, 1'b0};  // R14
                smi_q  <= SM_RD;
              end else begin
                smi_q <= SM_WR;
              end
            end
          end
          SM_RD: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `SWG_DATA_LAST) begin
              mdio_oe <= 1'b0;
              mdio_o  <= 1'b0;
              smi_q   <= SM_PRE;
            end else begin
              mdio_o <= sh_q[15];
              sh_q   <= {sh_q[14:0], 1'b0};
            end
          end
          SM_WR: begin
            cnt_q <= cnt_q + 4'h1;
            sh_q  <= {sh_q[14:0], pins_s[2]};
            if (cnt_q == `SWG_DATA_LAST) begin
              // The upper byte is shifted through and dropped.
              wr_q      <= 1'b1;
              wr_data_q <= {sh_q[6:0], pins_s[2]};  // R14
              smi_q     <= SM_PRE;
            end
          end
          default: begin
            smi_q <= SM_PRE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration memory loader.

  swg_ee_state_t  ee_q;         // Loader state.
  logic [7:0]     ee_b0_q;      // Stored family byte.
  logic [7:0]     ee_b1_q;      // Stored id byte.
  logic           ee_load_q;    // One-cycle pulse: checked image loads control byte.
  logic [7:0]     ee_b2_q;      // Control byte to load.

  // Only the (0,0) straps read the memory; other straps skip straight to done.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ee_q      <= EE_WAIT;
      ee_req    <= 1'b0;
      ee_addr   <= 8'h00;
      ee_b0_q   <= 8'h00;
      ee_b1_q   <= 8'h00;
      ee_b2_q   <= 8'h00;
      ee_load_q <= 1'b0;
    end else begin
      ee_load_q <= 1'b0;
      case (ee_q)
        EE_WAIT: begin
          if (strap_ok_q) begin
            if (strap_q == 2'h0 && ee_present) begin
              ee_q <= EE_REQ;
            end else begin
              ee_q <= EE_DONE;  // R5
            end
          end
        end
        EE_REQ: begin
          ee_req <= 1'b1;
          ee_q   <= EE_DATA;
        end
        EE_DATA: begin
          if (ee_rvalid) begin
            ee_req <= 1'b0;
            if (ee_addr == 8'h00) begin
              ee_b0_q <= ee_rdata;
            end else if (ee_addr == 8'h01) begin
              ee_b1_q <= ee_rdata;
            end else begin
              ee_b2_q <= ee_rdata;
            end
            if (ee_addr == `SWG_EE_LAST_ADDR) begin
              ee_load_q <= (ee_b0_q == FAMILY_CODE) && (ee_b1_q[7:4] == 4'h0);  // R6
              ee_q      <= EE_DONE;
            end else begin
              ee_addr <= ee_addr + 8'h01;
              ee_q    <= EE_REQ;
            end
          end
        end
        default: begin
          ee_q <= EE_DONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start control and back-off select.

  logic wr_id;   // Write to the id/start register.
  logic wr_gc0;  // Write to global control zero.

  assign wr_id  = wr_q && addr_q == `SWG_ADDR_ID_START;
  assign wr_gc0 = wr_q && addr_q == `SWG_ADDR_GCTRL0;

  // Host mode obeys the start bit; (0,0) starts once the loader is finished.
  // The (1,1) test straps never start, which is safe if the board keeps them out of use.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switch_start <= `SWG_START_RST;  // R3
    end else if (host_mode && wr_id) begin
      switch_start <= wr_data_q[`SWG_START_BIT];  // R2
    end else if (ee_q == EE_DONE && strap_q == 2'h0 && strap_ok_q) begin
      switch_start <= 1'b1;  // R4
    end
  end

  // A later host write overrides whatever the memory image loaded.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      backoff_alt <= `SWG_BACKOFF_RST;
    end else if (wr_gc0) begin
      backoff_alt <= wr_data_q[`SWG_BACKOFF_BIT];  // R8
    end else if (ee_load_q) begin
      backoff_alt <= ee_b2_q[`SWG_BACKOFF_BIT];  // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flush triggers.

  // A new trigger wins over a done pulse in the same cycle; the mask is the set of
  // learning-disabled ports so the table only drops entries tied to those ports.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush_dyn <= '0;
      flush_sta <= '0;
    end else begin
      if (wr_gc0 && wr_data_q[`SWG_FLUSH_DYN_BIT]) begin
        flush_dyn <= '{active: 1'b1, port_mask: learn_dis};  // R9 R10
      end else if (flush_dyn_done) begin
        flush_dyn.active <= 1'b0;  // R15
      end
      if (wr_gc0 && wr_data_q[`SWG_FLUSH_STA_BIT]) begin
        flush_sta <= '{active: 1'b1, port_mask: learn_dis};  // R11 R12
      end else if (flush_sta_done) begin
        flush_sta.active <= 1'b0;  // R15
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    if (addr_q == `SWG_ADDR_FAMILY) begin
      rd_data = FAMILY_CODE;
    end else if (addr_q == `SWG_ADDR_ID_START) begin
      rd_data = {CHIP_CODE, `SWG_REVISION_RST, switch_start};  // R1
    end else if (addr_q == `SWG_ADDR_GCTRL0) begin
      rd_data = {backoff_alt, 1'b0, flush_dyn.active, flush_sta.active, 4'h0};  // R15
    end else begin
      rd_data = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_dyn_trigger;
    wr_gc0 && wr_data_q[`SWG_FLUSH_DYN_BIT];
  endsequence

  sequence s_sta_trigger;
    wr_gc0 && wr_data_q[`SWG_FLUSH_STA_BIT];
  endsequence

  property p_rev_zero;
    @(posedge clk) disable iff (!rst_b)
      smi_q == SM_RD && addr_q == `SWG_ADDR_ID_START && cnt_q >= 4'hC && cnt_q <= 4'hE
        |-> mdio_oe && !mdio_o;
  endproperty
  a_rev_zero: assert property (p_rev_zero) else $error("revision not zero");  // R1

  property p_host_start;
    @(posedge clk) disable iff (!rst_b)
      host_mode && wr_id && wr_data_q[0] |=> switch_start;
  endproperty
  a_host_start: assert property (p_host_start) else $error("start write ignored");  // R2

  property p_stay_idle;
    @(posedge clk) disable iff (!rst_b)
      host_mode && !switch_start && !wr_id |=> !switch_start;
  endproperty
  a_stay_idle: assert property (p_stay_idle) else $error("started without write");  // R3

  property p_auto_start;
    @(posedge clk) disable iff (!rst_b)
      strap_ok_q && strap_q == 2'h0 && ee_q == EE_DONE && !wr_id |=> switch_start;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no auto start");  // R4

  property p_load_checked;
    @(posedge clk) disable iff (!rst_b)
      ee_load_q |-> ee_b0_q == FAMILY_CODE && ee_b1_q[7:4] == 4'h0 && ee_present;
  endproperty
  a_load_checked: assert property (p_load_checked) else $error("bad image loaded");  // R5 R6

  property p_dyn_flush;
    @(posedge clk) disable iff (!rst_b)
      s_dyn_trigger |=> flush_dyn.active && flush_dyn.port_mask == $past(learn_dis);
  endproperty
  a_dyn_flush: assert property (p_dyn_flush) else $error("dynamic flush missed");  // R9 R10

  property p_sta_flush;
    @(posedge clk) disable iff (!rst_b)
      s_sta_trigger |=> flush_sta.active && flush_sta.port_mask == $past(learn_dis);
  endproperty
  a_sta_flush: assert property (p_sta_flush) else $error("static flush missed");  // R11 R12

  property p_flush_hold;
    @(posedge clk) disable iff (!rst_b)
      flush_dyn.active && !flush_dyn_done |=> flush_dyn.active;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush bit dropped early");  // R15

  property p_upper_zero;
    @(posedge clk) disable iff (!rst_b)
      smi_q == SM_RD && cnt_q < 4'h8 |-> mdio_oe && !mdio_o;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");  // R14

endmodule

// ### dv/swg_far_model.sv
// Far-side model: configuration memory byte port and address table flush handshakes.
`timescale 1ns/1ps
module swg_far_model
  import swg_pkg::*;
#(
  parameter logic [10:0] DONE_DLY = 11'h4B0  // Flush length in clocks, longer than a read frame.
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Memory image and answer pace.
  input  wire logic        ee_present,
  input  wire logic [3:0]  ee_dly,
  input  wire logic [23:0] img,
  // Memory byte port.
  input  wire logic        ee_req,
  input  wire logic [7:0]  ee_addr,
  output logic             ee_rvalid,
  output logic [7:0]       ee_rdata,
  // Table flush handshakes.
  input  wire swg_flush_t  flush_dyn,
  output logic             flush_dyn_done,
  input  wire swg_flush_t  flush_sta,
  output logic             flush_sta_done
);
  logic [3:0]  wait_q;  // Clocks spent on the pending memory request.
  logic [10:0] dyn_q;   // Clocks spent on the dynamic flush.
  logic [10:0] sta_q;   // Clocks spent on the static flush.

  ////////////////////////////////////////////////////////////////////////////
  // Memory answers after ee_dly clocks; outside the pulse the data toggles so
  // that a design sampling it at the wrong time cannot see a stale byte.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_q    <= 4'h0;
      ee_rvalid <= 1'h0;
      ee_rdata  <= 8'h00;
    end else if (ee_rvalid) begin
      wait_q    <= 4'h0;
      ee_rvalid <= 1'h0;
      ee_rdata  <= ~ee_rdata;
    end else if (ee_req && ee_present && wait_q == ee_dly) begin
      ee_rvalid <= 1'h1;
      // Image bytes: family code, identity byte, back-off byte.
      case (ee_addr[1:0])
        2'h0: ee_rdata <= img[23:16];
        2'h1: ee_rdata <= img[15:8];
        default: ee_rdata <= img[7:0];
      endcase
    end else begin
      wait_q   <= (ee_req && ee_present) ? wait_q + 4'h1 : 4'h0;
      ee_rdata <= ~ee_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The table finishes a dynamic flush a fixed time after it is asked for.
  always_ff @(posedge clk) begin
    if (!rst_b || !flush_dyn.active || flush_dyn_done) begin
      dyn_q          <= 11'h000;
      flush_dyn_done <= 1'h0;
    end else begin
      dyn_q          <= dyn_q + 11'h001;
      flush_dyn_done <= (dyn_q == DONE_DLY);
    end
  end

  // The static flush is answered the same way.
  always_ff @(posedge clk) begin
    if (!rst_b || !flush_sta.active || flush_sta_done) begin
      sta_q          <= 11'h000;
      flush_sta_done <= 1'h0;
    end else begin
      sta_q          <= sta_q + 11'h001;
      flush_sta_done <= (sta_q == DONE_DLY);
    end
  end
endmodule

// ### dv/tb.sv
// Self-checking bench for the global id, start and flush register bank.
`timescale 1ns/1ps
`include "swg_params.svh"
module tb
  import swg_pkg::*;
;
  localparam logic [7:0] FAM  = 8'h3C;  // Arbitrary family value.
  localparam logic [3:0] CHIP = 4'h9;   // Arbitrary chip value.
  logic        clk, rst_b, mdc, host_oe, host_d, mdio_o, mdio_oe;
  logic        mode_strap_high, mode_strap_low, ee_present, ee_req, ee_rvalid;
  logic        switch_start, backoff_alt, flush_dyn_done, flush_sta_done;
  logic [7:0]  ee_addr, ee_rdata;
  logic [23:0] img;
  logic [3:0]  ee_dly;
  logic [4:0]  learn_dis;
  swg_flush_t  flush_dyn, flush_sta;
  int          bad_count, n_checks;
  // The shared line has a pull-up, so nobody driving reads as one.
  wire mdio_w = mdio_oe ? mdio_o : (host_oe ? host_d : 1'h1);

  swg_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP)) dut_u (
    .clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mode_strap_high(mode_strap_high), .mode_strap_low(mode_strap_low),
    .ee_present(ee_present), .ee_req(ee_req), .ee_addr(ee_addr), .ee_rvalid(ee_rvalid),
    .ee_rdata(ee_rdata), .switch_start(switch_start), .backoff_alt(backoff_alt),
    .learn_dis(learn_dis), .flush_dyn(flush_dyn), .flush_dyn_done(flush_dyn_done),
    .flush_sta(flush_sta), .flush_sta_done(flush_sta_done));

  swg_far_model far_u (
    .clk(clk), .rst_b(rst_b), .ee_present(ee_present), .ee_dly(ee_dly), .img(img),
    .ee_req(ee_req), .ee_addr(ee_addr), .ee_rvalid(ee_rvalid), .ee_rdata(ee_rdata),
    .flush_dyn(flush_dyn), .flush_dyn_done(flush_dyn_done),
    .flush_sta(flush_sta), .flush_sta_done(flush_sta_done));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, common tasks and the verdict.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A wait that ran out of its bound ends the run as a failure.
  task automatic limit(input int k, input int lim);
    if (k >= lim) begin
      chk(16'h0000, 16'h0001, "wait ran out");
      end_of_test();
    end
  endtask

  // Straps are only ever (1,0), (0,1) or (0,0); (1,1) is left to the factory.
  task automatic do_reset(input logic sh, input logic sl, input logic pr, input logic [23:0] im);
    rst_b = 1'h0;
    mode_strap_high = sh;
    mode_strap_low = sl;
    ee_present = pr;
    img = im;
    wclk(20);
    rst_b = 1'h1;
    wclk(2);
  endtask

  // One management frame; MDC runs at an eighth of clk, reads are sampled late in each bit.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [45:0] hdr;
    logic [17:0] wf;
    hdr = {32'hFFFFFFFF, 2'h1, op, phy, ra};
    wf = {2'h2, wd};
    for (int i = 45; i >= 0; i--) begin
      mdc = 1'h0;
      host_oe = 1'h1;
      host_d = hdr[i];
      wclk(4);
      mdc = 1'h1;
      wclk(4);
    end
    for (int j = 0; j < 19; j++) begin
      mdc = 1'h0;
      host_oe = (op == `SWG_OP_WRITE) && j < 18;
      host_d = (j < 18) ? wf[17-j] : 1'h1;
      wclk(4);
      if (j == 1) ta = mdio_w;
      if (j >= 2 && j < 18) rd[17-j] = mdio_w;
      mdc = 1'h1;
      wclk(4);
    end
    host_oe = 1'h1;
    wclk(4);
  endtask

  // Register access by 8-bit address split across the two header fields.
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    logic        ta;
    frame(`SWG_OP_READ, {a[7], a[6], 2'h3, a[5]}, a[4:0], 16'h0000, d, ta);
    chk({15'h0000, ta}, 16'h0000, "turnaround zero");
    chk({15'h0000, mdio_oe}, 16'h0000, "line released");
    chk(d, exp, what);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] wd);
    logic [15:0] d;
    logic        ta;
    frame(`SWG_OP_WRITE, {a[7], a[6], 2'h3, a[5]}, a[4:0], wd, d, ta);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_ident();
    do_reset(1'h1, 1'h0, 1'h0, 24'h000000);
    wclk(100);
    chk({15'h0000, switch_start}, 16'h0000, "idle without start");
    reg_wr(`SWG_ADDR_FAMILY, 16'hFFFF);
    reg_rd(`SWG_ADDR_FAMILY, {8'h00, FAM}, "family");
    reg_rd(`SWG_ADDR_ID_START, {8'h00, CHIP, 4'h0}, "revision");
    reg_rd(`SWG_ADDR_GCTRL0, 16'h0000, "control reset");
    reg_rd(8'h03, 16'h0000, "unmapped");
  endtask

  // Host mode start for both host strap settings, upper byte of ones ignored.
  task automatic t_start();
    for (int s = 0; s < 2; s++) begin
      do_reset(s == 0, s == 1, 1'h0, 24'h000000);
      reg_wr(`SWG_ADDR_ID_START, 16'hFF01);
      wclk(4);
      chk({15'h0000, switch_start}, 16'h0001, "start");
      reg_rd(`SWG_ADDR_ID_START, {8'h00, CHIP, 4'h1}, "start readback");
      reg_wr(`SWG_ADDR_ID_START, 16'h0000);
      wclk(4);
      chk({15'h0000, switch_start}, 16'h0000, "stop");
    end
  endtask

  // Back-off select, reserved bit 6, and frames for another register or another device.
  task automatic t_backoff();
    logic [15:0] d;
    logic        ta;
    reg_wr(`SWG_ADDR_GCTRL0, 16'hFF80);
    chk({15'h0000, backoff_alt}, 16'h0001, "back-off on");
    reg_rd(`SWG_ADDR_GCTRL0, 16'h0080, "back-off readback");
    reg_wr(`SWG_ADDR_GCTRL0, 16'h0040);
    chk({15'h0000, backoff_alt}, 16'h0000, "back-off off");
    reg_rd(`SWG_ADDR_GCTRL0, 16'h0000, "reserved bit");
    frame(`SWG_OP_WRITE, 5'h07, 5'h02, 16'h0080, d, ta);
    frame(`SWG_OP_WRITE, 5'h04, 5'h02, 16'h0080, d, ta);
    chk({15'h0000, backoff_alt}, 16'h0000, "other address");
    frame(`SWG_OP_READ, 5'h02, 5'h02, 16'h0000, d, ta);
    chk({ta, d[14:0]}, 16'hFFFF, "foreign read undriven");
  endtask

  // Each flush bit: mask taken at the write, reads one until the table is done.
  task automatic t_flush();
    swg_flush_t f;
    int         k;
    for (int b = 4; b < 6; b++) begin
      learn_dis = 5'h15;
      reg_wr(`SWG_ADDR_GCTRL0, 16'h0001 << b);
      learn_dis = 5'h0A;
      f = (b == 5) ? flush_dyn : flush_sta;
      chk({10'h000, f}, 16'h0035, "flush request");
      f = (b == 5) ? flush_sta : flush_dyn;
      chk({15'h0000, f.active}, 16'h0000, "other flush idle");
      reg_rd(`SWG_ADDR_GCTRL0, 16'h0001 << b, "flush busy");
      for (k = 0; k < 1500 && (flush_dyn.active | flush_sta.active) !== 1'h0; k++) wclk(1);
      limit(k, 1500);
      reg_rd(`SWG_ADDR_GCTRL0, 16'h0000, "flush cleared");
    end
    learn_dis = 5'h00;
  endtask

  // Strap (0,0): automatic start with memory absent, good image and two bad images.
  task automatic t_auto();
    logic [24:0] cs [4];
    logic        exp;
    int          k;
    cs = '{{1'h0, FAM, 16'h0080}, {1'h1, FAM, 16'h0080}, {1'h1, FAM, 16'h1080},
           {1'h1, ~FAM, 16'h0080}};
    for (int c = 0; c < 4; c++) begin
      ee_dly = (c == 1) ? 4'h9 : 4'h0;
      exp = (c == 1);
      do_reset(1'h0, 1'h0, cs[c][24], cs[c][23:0]);
      for (k = 0; k < 300 && switch_start !== 1'h1; k++) wclk(1);
      limit(k, 300);
      wclk(1);
      chk({15'h0000, backoff_alt}, {15'h0000, exp}, "image load");
      reg_rd(`SWG_ADDR_GCTRL0, {8'h00, exp, 7'h00}, "loaded control");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    bad_count = 0;
    n_checks = 0;
    mdc = 1'h0;
    host_oe = 1'h1;
    host_d = 1'h1;
    learn_dis = 5'h00;
    ee_dly = 4'h0;
    do_reset(1'h1, 1'h0, 1'h0, 24'h000000);
    t_ident();
    t_start();
    t_backoff();
    t_flush();
    t_auto();
    end_of_test();
  end
endmodule
